/* File: design/processor_hot_monitor.sv */
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - core clock registers, 100 kHz tick counters
// - system reset clears every register
// - soft reset clears all but the pin synchroniser; sleep does not
// - sleep or soft reset clears counters, filter
// - event from enabled assertion or period status
// - idle after reset until monitor enable set
// - optional three-stage filter drops short pulses
// - assertion counter counts low, clears high
// - counter at or above limit sets status
// - assertion status sticky until cleared
// - duty start clears active, loads period
// - duty counters run until disable or zero
// - active counter counts low, holds high
// - active cleared: disable, period write, wrap
// - cumulative count shows live active counter
// - period end copies count, flags, reloads
// - runs of fifty ticks or fewer discarded
// - counts are twenty-four bits wide
// - byte zero read latches upper bytes
module processor_hot_monitor
   import hot_monitor_pkg::*;
#(
   parameter int ASSERT_WIDTH = ASSERT_W,
   parameter int DIVIDE = TICK_DIV
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic hot_alert_n,
   input wire logic monitor_enable,
   input wire logic glitch_filter_enable,
   input wire logic monitor_soft_reset,
   input wire logic sleep_request,
   input wire logic assert_event_enable,
   input wire logic period_event_enable,
   input wire logic [ASSERT_WIDTH-1:0] assert_limit,
   input wire logic [COUNT_W-1:0] period_value,
   input wire logic period_write,
   input wire logic assertion_status_clear,
   input wire logic period_status_clear,
   input wire logic cumulative_byte0_read,
   input wire logic duty_byte0_read,
   output logic hot_event,
   output logic assertion_status,
   output logic period_status,
   output logic [ASSERT_WIDTH-1:0] assertion_count,
   output logic [COUNT_W-1:0] cumulative_count,
   output logic [COUNT_W-1:0] duty_cycle_count,
   output logic [COUNT_W-1:0] cumulative_hold,
   output logic [COUNT_W-1:0] duty_hold
);

   localparam int DIV_W = $clog2(DIVIDE);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIVIDE - 1);
   localparam logic [DIV_W-1:0] DIV_ZERO = DIV_W'(0);
   localparam logic [COUNT_W-1:0] ONE = COUNT_W'(1);
   localparam logic [COUNT_W-1:0] RUN_LIMIT = COUNT_W'(RUN_DISCARD);
   localparam logic [COUNT_W-1:0] RUN_FIRST = COUNT_W'(RUN_DISCARD + 1);
   localparam logic [ASSERT_WIDTH-1:0] ASSERT_ZERO = ASSERT_WIDTH'(0);
   localparam logic [ASSERT_WIDTH-1:0] ASSERT_MAX = {ASSERT_WIDTH{1'b1}};

   // refuse settings the counters cannot serve
   if (DIVIDE < 2) begin : g_bad_divide
      $error("divider must be at least two core clocks");
   end
   if (ASSERT_WIDTH < 1 || ASSERT_WIDTH > COUNT_W) begin : g_bad_width
      $error("assertion counter width out of range");
   end

   // saturating add, never wraps past all ones
   function automatic logic [COUNT_W-1:0] sat_add(
      input logic [COUNT_W-1:0] a,
      input logic [COUNT_W-1:0] b
   );
      logic [COUNT_W:0] sum;
      sum = {1'b0, a} + {1'b0, b};
      sat_add = sum[COUNT_W] ? {COUNT_W{1'b1}} : sum[COUNT_W-1:0];
   endfunction

   // reset domains derived from the control inputs
   logic monitor_clear; // soft reset only, sleep leaves it alone
   logic sleep_clear; // soft reset or sleep
   assign monitor_clear = monitor_soft_reset;
   assign sleep_clear = monitor_soft_reset | sleep_request;

   // pin synchroniser, three stages
   logic sync_a; // first stage, read only by sync_b
   logic sync_b; // second stage
   logic sync_c; // third stage
   logic pin_level; // accepted pin level

   // pin is asynchronous; accept a change once stages two and three agree
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sync_a <= PIN_IDLE;
         sync_b <= PIN_IDLE;
         sync_c <= PIN_IDLE;
         pin_level <= PIN_IDLE;
      end else begin
         sync_a <= hot_alert_n;
         sync_b <= sync_a;
         sync_c <= sync_b;
         if (sync_b == sync_c) begin
            pin_level <= sync_c;
         end
      end
   end

   // counter tick divider
   logic [DIV_W-1:0] div_count; // core clocks since last tick
   logic tick; // one core clock wide, once per counter period
   logic div_wrap; // last count of the divider

   assign div_wrap = (div_count == DIV_LAST);

   // derive the slow counter rate from the core clock
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         div_count <= DIV_ZERO;
         tick <= 1'b0;
      end else if (sleep_clear) begin
         div_count <= DIV_ZERO;
         tick <= 1'b0;
      end else begin
         div_count <= div_wrap ? DIV_ZERO : div_count + 1'b1;
         tick <= div_wrap;
      end
   end

   // glitch filter on the tick
   logic filtered_n; // filtered pin, still active low
   logic hot_active; // processor running hot

   hot_glitch_filter u_filter (
      .core_clk(core_clk),
      .rst(rst),
      .tick(tick),
      .clear(sleep_clear),
      .enable(glitch_filter_enable),
      .din(pin_level),
      .dout(filtered_n)
   );

   // low level on the pin is the hot condition
   assign hot_active = monitor_enable & ~filtered_n;

   // assertion counter
   logic assert_at_max; // counter saturated
   logic assert_reached; // counter at or past the limit
   logic [ASSERT_WIDTH-1:0] next_assertion_count;

   assign assert_at_max = (assertion_count == ASSERT_MAX);
   assign assert_reached = hot_active && (assertion_count >= assert_limit);

   // count while hot, drop to zero when cool or disabled
   always_comb begin
      next_assertion_count = assertion_count;
      if (!monitor_enable) begin
         next_assertion_count = ASSERT_ZERO;
      end else if (tick) begin
         if (!hot_active) begin
            next_assertion_count = ASSERT_ZERO;
         end else if (!assert_at_max) begin
            next_assertion_count = assertion_count + 1'b1;
         end
      end
   end

   // sleep domain register for the assertion counter
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         assertion_count <= ASSERT_ZERO;
      end else if (sleep_clear) begin
         assertion_count <= ASSERT_ZERO;
      end else begin
         assertion_count <= next_assertion_count;
      end
   end

   // duty cycle monitor
   duty_state_e duty_state;
   duty_state_e next_duty_state;
   logic duty_on; // both conditions for duty monitoring hold
   logic duty_start; // first cycle of duty monitoring
   logic [COUNT_W-1:0] period_count; // counts down to the period end
   logic [COUNT_W-1:0] run_length; // ticks of the current hot run
   logic period_end; // period counter at one on a tick, reloads instead of reaching zero
   logic run_long; // current run already past the discard limit
   logic run_crossing; // run passes the discard limit this tick
   logic [COUNT_W-1:0] next_period_count;
   logic [COUNT_W-1:0] next_run_length;
   logic [COUNT_W-1:0] next_active;

   assign duty_on = monitor_enable && (period_value != COUNT_RESET);
   assign duty_start = duty_on && (duty_state == DUTY_IDLE);
   assign period_end = tick && (duty_state == DUTY_RUN) && duty_on &&
      (period_count == ONE);
   assign run_long = (run_length > RUN_LIMIT);
   assign run_crossing = (run_length == RUN_LIMIT);

   // enter on enable with a nonzero period, leave on disable or zero
   always_comb begin
      next_duty_state = duty_state;
      unique case (duty_state)
         DUTY_IDLE: begin
            if (duty_on) begin
               next_duty_state = DUTY_RUN;
            end
         end
         DUTY_RUN: begin
            if (!duty_on) begin
               next_duty_state = DUTY_IDLE;
            end
         end
      endcase
   end

   // period counter: load on start or write, count down, reload at end
   always_comb begin
      next_period_count = period_count;
      if (!duty_on) begin
         next_period_count = period_count;
      end else if (duty_start || period_write) begin
         next_period_count = period_value;
      end else if (period_end) begin
         next_period_count = period_value;
      end else if (tick) begin
         next_period_count = period_count - ONE;
      end
   end

   // length of the present hot run, zero while cool
   always_comb begin
      next_run_length = run_length;
      if (!monitor_enable) begin
         next_run_length = COUNT_RESET;
      end else if (tick) begin
         next_run_length = hot_active ? sat_add(run_length, ONE) :
            COUNT_RESET;
      end
   end

   // active time: short runs add nothing, a long run adds its whole length
   always_comb begin
      next_active = cumulative_count;
      if (!monitor_enable || duty_start || period_write || period_end) begin
         next_active = COUNT_RESET;
      end else if (!duty_on) begin
         next_active = cumulative_count;
      end else if (tick && hot_active) begin
         if (run_long) begin
            next_active = sat_add(cumulative_count, ONE);
         end else if (run_crossing) begin
            next_active = sat_add(cumulative_count, RUN_FIRST);
         end
      end
   end

   // sleep domain registers of the duty cycle monitor
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         duty_state <= DUTY_IDLE;
         period_count <= COUNT_RESET;
         run_length <= COUNT_RESET;
         cumulative_count <= COUNT_RESET;
         duty_cycle_count <= COUNT_RESET;
      end else if (sleep_clear) begin
         duty_state <= DUTY_IDLE;
         period_count <= COUNT_RESET;
         run_length <= COUNT_RESET;
         cumulative_count <= COUNT_RESET;
         duty_cycle_count <= COUNT_RESET;
      end else begin
         duty_state <= next_duty_state;
         period_count <= next_period_count;
         run_length <= next_run_length;
         cumulative_count <= next_active;
         if (period_end) begin
            duty_cycle_count <= cumulative_count;
         end
      end
   end

   // sticky status bits, set beats clear
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         assertion_status <= 1'b0;
         period_status <= 1'b0;
      end else if (monitor_clear) begin
         assertion_status <= 1'b0;
         period_status <= 1'b0;
      end else begin
         if (assert_reached) begin
            assertion_status <= 1'b1;
         end else if (assertion_status_clear) begin
            assertion_status <= 1'b0;
         end
         if (period_end) begin
            period_status <= 1'b1;
         end else if (period_status_clear) begin
            period_status <= 1'b0;
         end
      end
   end

   // combined event from the enabled status bits
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hot_event <= 1'b0;
      end else if (monitor_clear) begin
         hot_event <= 1'b0;
      end else begin
         hot_event <= (assertion_status & assert_event_enable) |
            (period_status & period_event_enable);
      end
   end

   // upper bytes caught when byte zero is read
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cumulative_hold <= COUNT_RESET;
         duty_hold <= COUNT_RESET;
      end else if (monitor_clear) begin
         cumulative_hold <= COUNT_RESET;
         duty_hold <= COUNT_RESET;
      end else begin
         if (cumulative_byte0_read) begin
            cumulative_hold <= {8'h00, cumulative_count[23:8]};
         end
         if (duty_byte0_read) begin
            duty_hold <= {8'h00, duty_cycle_count[23:8]};
         end
      end
   end

endmodule

`default_nettype wire

/* File: design/hot_monitor_pkg.sv */
package hot_monitor_pkg;

   // core clock rate and the slow counter rate
   localparam int CORE_CLK_HZ = 40_000_000;
   localparam int COUNTER_CLK_HZ = 100_000;
   // core clocks per counter tick, derived from the two rates
   localparam int TICK_DIV = CORE_CLK_HZ / COUNTER_CLK_HZ;

   // width of the cumulative and duty cycle counts
   localparam int COUNT_W = 24;
   // default width of the assertion counter and its limit
   localparam int ASSERT_W = 16;

   // runs of this many ticks or fewer never reach the active time
   localparam int RUN_DISCARD = 50;

   // idle level of the active-low hot alert pin
   localparam logic PIN_IDLE = 1'b1;

   // reset value of the 24-bit counters and hold registers
   localparam logic [COUNT_W-1:0] COUNT_RESET = 24'h000000;

   // duty cycle monitor states
   typedef enum logic {
      DUTY_IDLE = 1'b0,
      DUTY_RUN = 1'b1
   } duty_state_e;

endpackage

/* File: design/hot_glitch_filter.sv */
`timescale 1ns/10ps
`default_nettype none

// three-stage majority-free filter: when enabled, the output follows only once three
// consecutive counter-tick samples agree, so short pulses die here
module hot_glitch_filter
   import hot_monitor_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic clear,
   input wire logic enable,
   input wire logic din,
   output logic dout
);

   logic [2:0] stage; // sample history, newest in bit 0
   logic held; // filtered level
   logic agree_low; // all samples low
   logic agree_high; // all samples high

   assign agree_low = (stage == 3'h0);
   assign agree_high = (stage == 3'h7);
   // bypass when the filter is switched off
   assign dout = enable ? held : din;

   // sample on each counter tick, clear on sleep or soft reset
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         stage <= 3'h7;
         held <= PIN_IDLE;
      end else if (clear) begin
         stage <= 3'h7;
         held <= PIN_IDLE;
      end else if (tick) begin
         stage <= {stage[1:0], din};
         if (agree_low) begin
            held <= 1'b0;
         end else if (agree_high) begin
            held <= 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

/* File: bench/processor_hot_monitor_sva.sv */
`timescale 1ns/10ps
`default_nettype none

// watches the monitor ports: event, sticky status and count relations
module processor_hot_monitor_sva
   import hot_monitor_pkg::*;
#(
   parameter int ASSERT_WIDTH = ASSERT_W,
   parameter int DIVIDE = TICK_DIV
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic monitor_enable,
   input wire logic monitor_soft_reset,
   input wire logic assert_event_enable,
   input wire logic period_event_enable,
   input wire logic [ASSERT_WIDTH-1:0] assert_limit,
   input wire logic assertion_status_clear,
   input wire logic cumulative_byte0_read,
   input wire logic duty_byte0_read,
   input wire logic hot_event,
   input wire logic assertion_status,
   input wire logic period_status,
   input wire logic [ASSERT_WIDTH-1:0] assertion_count,
   input wire logic [COUNT_W-1:0] cumulative_count,
   input wire logic [COUNT_W-1:0] duty_cycle_count,
   input wire logic [COUNT_W-1:0] cumulative_hold,
   input wire logic [COUNT_W-1:0] duty_hold
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   // either enabled status source
   wire logic ev_src = (assertion_status && assert_event_enable) ||
      (period_status && period_event_enable);

   chk_event_follow: assert property (
      !monitor_soft_reset |=> hot_event == $past(ev_src))
      else $error("hot event does not follow enabled status");
   chk_status_sticky: assert property (
      assertion_status && !assertion_status_clear && !monitor_soft_reset
      |=> assertion_status)
      else $error("assertion status dropped without a clear");
   chk_status_cause: assert property (
      $rose(assertion_status) |->
      $past(assertion_count) >= $past(assert_limit))
      else $error("assertion status set below the limit");
   chk_count_step: assert property (
      assertion_count != $past(assertion_count) |->
      assertion_count == $past(assertion_count) + 16'h0001 ||
      assertion_count == 16'h0000)
      else $error("assertion count moved by other than one");
   chk_idle_zero: assert property (
      !monitor_enable [*6] |->
      assertion_count == 16'h0000 && cumulative_count == 24'h000000)
      else $error("counters move while monitor disabled");
   chk_cum_drop: assert property (
      cumulative_count < $past(cumulative_count) |->
      cumulative_count == 24'h000000)
      else $error("active time fell without a clear");
   chk_period_end: assert property (
      $rose(period_status) |-> cumulative_count == 24'h000000)
      else $error("active time kept at period end");
   chk_cum_hold: assert property (
      cumulative_byte0_read && !monitor_soft_reset |=>
      cumulative_hold == $past(cumulative_count) >> 8)
      else $error("cumulative upper bytes not latched");
   chk_duty_hold: assert property (
      duty_byte0_read && !monitor_soft_reset |=>
      duty_hold == $past(duty_cycle_count) >> 8)
      else $error("duty upper bytes not latched");

   // main scenarios reached
   cov_assert: cover property ($rose(assertion_status));
   cov_period: cover property ($rose(period_status));
   cov_event: cover property ($rose(hot_event));
   cov_long: cover property (cumulative_count > 24'h000032);
endmodule

bind processor_hot_monitor processor_hot_monitor_sva #(
   .ASSERT_WIDTH(ASSERT_WIDTH),
   .DIVIDE(DIVIDE)
) i_processor_hot_monitor_sva (
   .core_clk(core_clk), .rst(rst), .monitor_enable(monitor_enable),
   .monitor_soft_reset(monitor_soft_reset),
   .assert_event_enable(assert_event_enable),
   .period_event_enable(period_event_enable), .assert_limit(assert_limit),
   .assertion_status_clear(assertion_status_clear),
   .cumulative_byte0_read(cumulative_byte0_read),
   .duty_byte0_read(duty_byte0_read), .hot_event(hot_event),
   .assertion_status(assertion_status), .period_status(period_status),
   .assertion_count(assertion_count), .cumulative_count(cumulative_count),
   .duty_cycle_count(duty_cycle_count), .cumulative_hold(cumulative_hold),
   .duty_hold(duty_hold)
);

`default_nettype wire

/* File: bench/hot_host_model.sv */
`timescale 1ns/10ps
`default_nettype none

// host side: holds the active-low hot alert pin low for a set time
module hot_host_model (
   input wire logic core_clk,
   input wire logic start,
   input wire logic [15:0] low_cycles,
   output logic hot_alert_n,
   output logic busy
);
   logic [15:0] left = 16'h0000; // clocks of low drive still to go
   // load on start, then count the low time down
   always @(posedge core_clk) begin
      if (start) begin
         left <= low_cycles;
      end else if (left != 16'h0000) begin
         left <= left - 16'h0001;
      end
   end
   assign busy = (left != 16'h0000);
   // low while hot, high (cool) at rest
   assign hot_alert_n = !busy;
endmodule

`default_nettype wire

/* File: bench/processor_hot_monitor_tb.sv */
`timescale 1ns/10ps
`default_nettype none

// runs of the hot alert pin, corner and random, against the monitor
module processor_hot_monitor_tb;
   import hot_monitor_pkg::*;
   localparam int DIV = 4; // short tick divider for simulation
   logic core_clk = 1'b0, rst = 1'b1, en = 1'b0, filt = 1'b1;
   logic srst = 1'b0, slp = 1'b0, aee = 1'b0, pee = 1'b0, pw = 1'b0;
   logic aclr = 1'b0, pclr = 1'b0, crd = 1'b0, drd = 1'b0, go = 1'b0;
   logic [15:0] lim = 16'h0003, len = 16'h0000, mid, aft;
   logic [23:0] per = 24'h000000;
   wire logic pin, busy, ev, ast, pst;
   wire logic [15:0] acnt;
   wire logic [23:0] cum, duty, chold, dhold;
   int error_cnt = 0, samples_checked = 0, cyc = 0, seed = 49934, n, l;

   processor_hot_monitor #(.DIVIDE(DIV)) i_processor_hot_monitor (
      .core_clk(core_clk), .rst(rst), .hot_alert_n(pin),
      .monitor_enable(en), .glitch_filter_enable(filt),
      .monitor_soft_reset(srst), .sleep_request(slp),
      .assert_event_enable(aee), .period_event_enable(pee),
      .assert_limit(lim), .period_value(per), .period_write(pw),
      .assertion_status_clear(aclr), .period_status_clear(pclr),
      .cumulative_byte0_read(crd), .duty_byte0_read(drd),
      .hot_event(ev), .assertion_status(ast), .period_status(pst),
      .assertion_count(acnt), .cumulative_count(cum),
      .duty_cycle_count(duty), .cumulative_hold(chold), .duty_hold(dhold));
   hot_host_model i_hot_host_model (.core_clk(core_clk), .start(go),
      .low_cycles(len), .hot_alert_n(pin), .busy(busy));

   always #12.5 core_clk = !core_clk;
   // hang guard
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         stop_test();
      end
   end

   // range comparison; exact when lo equals hi
   task automatic check(input logic [23:0] got, input int lo, input int hi);
      samples_checked++;
      if (((got >= lo) && (got <= hi)) !== 1'b1) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask
   // expected active time for one low run of t ticks, with slack d
   function automatic int act(input int t, input int d);
      return (t > RUN_DISCARD) ? t + d : 0;
   endfunction
   task automatic ticks(input int t);
      repeat (t * DIV) @(posedge core_clk);
   endtask
   // low run of t ticks; count sampled after m ticks, optional sleep
   task automatic run(input int t, input int m, input logic s);
      // align to an edge so every input moves on the rising edge
      @(posedge core_clk);
      go <= 1'b1;
      len <= 16'(t * DIV);
      @(posedge core_clk);
      go <= 1'b0;
      ticks(m);
      slp <= s;
      #1 mid = acnt;
      @(posedge core_clk);
      slp <= 1'b0;
      #1 aft = acnt;
      while (busy === 1'b1) @(posedge core_clk);
      ticks(8);
   endtask
   // period write with byte-0 reads alongside
   task automatic wr_period(input logic [23:0] v);
      @(posedge core_clk);
      per <= v;
      pw <= 1'b1;
      crd <= 1'b1;
      drd <= 1'b1;
      @(posedge core_clk);
      pw <= 1'b0;
      crd <= 1'b0;
      drd <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1 check(cum, 0, 0);
   endtask
   task automatic stop_test();
      $display("checks=%0d errors=%0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      #1 check(24'({ev, ast, pst, acnt}), 0, 0);
      check(cum | duty | chold | dhold, 0, 0);
      run(30, 20, 1'b0);
      check(24'(mid), 0, 0);
      en <= 1'b1;
      aee <= 1'b1;
      run(20, 15, 1'b0);
      check(24'(mid), 10, 15);
      check(24'({ast, ev, acnt}), 24'h030000, 24'h030000);
      aclr <= 1'b1;
      @(posedge core_clk);
      aclr <= 1'b0;
      lim <= 16'h0014;
      repeat (2) @(posedge core_clk);
      #1 check(24'({ast, ev}), 0, 0);
      run(15, 0, 1'b0);
      check(24'(ast), 0, 0);
      lim <= 16'h0001;
      for (n = 1; n >= 0; n--) begin
         filt <= n[0];
         run(2, 0, 1'b0);
         check(24'(ast), !n[0], !n[0]);
      end
      filt <= 1'b1;
      run(30, 20, 1'b1);
      check(24'({ast, aft}), 24'h010000, 24'h010000);
      srst <= 1'b1;
      @(posedge core_clk);
      srst <= 1'b0;
      #1 check(24'({ast, ev, acnt}), 0, 0);
      for (n = 0; n < 6; n++) begin
         // a 300-tick run at n == 2 carries the count past one byte
         l = (n == 0) ? 48 : (n == 1) ? 53 : (n == 2) ? 300 :
            57 + {$random(seed)} % 60;
         wr_period(24'h00FFFF);
         // the write's byte-0 read caught the long run's upper bytes
         if (n == 3) begin
            check(chold, act(300, -2) >> 8, act(300, 1) >> 8);
         end
         run(l, 0, 1'b0);
         check(cum, act(l, -2), act(l, 1));
      end
      pee <= 1'b1;
      aee <= 1'b0;
      // 288-tick period holding a 270-tick run: duty passes one byte
      wr_period(24'h000120);
      run(270, 0, 1'b0);
      while (pst !== 1'b1) @(posedge core_clk);
      #1 check(duty, act(270, -2), act(270, 1));
      check(cum, 0, 0);
      repeat (2) @(posedge core_clk);
      #1 check(24'(ev), 1, 1);
      wr_period(24'h000000);
      check(dhold, act(270, -2) >> 8, act(270, 1) >> 8);
      @(posedge core_clk);
      pclr <= 1'b1;
      @(posedge core_clk);
      pclr <= 1'b0;
      // longer than one period, so a counter left running would flag
      ticks(300);
      #1 check(24'(pst), 0, 0);
      stop_test();
   end
endmodule

`default_nettype wire
